// file: core/rxto_pkg.sv
// shared constants for the receive terminal output and loop-back block
package rxto_pkg;

	// register selects on the command port
	localparam logic [2:0] RXTO_REG_OUT_CTRL  = 3'h3;
	localparam logic [2:0] RXTO_REG_LOOP_CTRL = 3'h4;
	localparam int         RXTO_REG_WIDTH     = 5;

	// receive_output_control fields
	localparam int RXTO_OC_CLK_INV_BIT     = 1;
	localparam int RXTO_OC_RX_OFF_BIT      = 2;
	localparam int RXTO_OC_MUTE_BIT        = 3;
	localparam int RXTO_OC_SINGLE_RAIL_BIT = 4;
	localparam logic [4:0] RXTO_OC_WRITE_MASK = 5'h1e;
	localparam logic [4:0] RXTO_OC_RESET      = 5'h00;

	// loopback_and_rate_control fields
	localparam int RXTO_LC_REMOTE_LOOP_BIT = 0;
	localparam int RXTO_LC_LOCAL_LOOP_BIT  = 1;
	localparam int RXTO_LC_E3_BIT          = 2;
	localparam int RXTO_LC_STS1_BIT        = 3;
	localparam logic [4:0] RXTO_LC_WRITE_MASK = 5'h0f;
	localparam logic [4:0] RXTO_LC_RESET      = 5'h00;

	// nominal recovered clock rates, in kHz
	localparam int RXTO_RATE_E3_KHZ   = 34368;
	localparam int RXTO_RATE_DS3_KHZ  = 44736;
	localparam int RXTO_RATE_STS1_KHZ = 51840;

	// data path shape
	localparam int RXTO_FIFO_WIDTH = 2;
	localparam int RXTO_FIFO_DEPTH = 8;

	// synchronised pin vector positions
	localparam int RXTO_PIN_HW_MODE  = 0;
	localparam int RXTO_PIN_CLK_INV  = 1;
	localparam int RXTO_PIN_SINGLE   = 2;
	localparam int RXTO_PIN_RX_OFF   = 3;
	localparam int RXTO_PIN_LOCAL    = 4;
	localparam int RXTO_PIN_REMOTE   = 5;
	localparam int RXTO_PIN_TIP      = 6;
	localparam int RXTO_PIN_RING     = 7;
	localparam int RXTO_PIN_LINE_CLK = 8;
	localparam int RXTO_PIN_TX_POS   = 9;
	localparam int RXTO_PIN_TX_NEG   = 10;
	localparam int RXTO_PIN_TX_CLK   = 11;
	localparam int RXTO_PIN_COUNT    = 12;

	// output stage: idle, clock at launch level, clock at hold level
	typedef enum logic [1:0] {
		RXTO_ST_IDLE   = 2'b00,
		RXTO_ST_LAUNCH = 2'b01,
		RXTO_ST_HOLD   = 2'b11
	} rxto_state_t;

endpackage

// file: core/rxto_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module rxto_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             resetn_in,
	// flush
	input  wire logic             flush_in,
	// fill side
	input  wire logic             push_valid_in,
	output logic                  push_ready_out,
	input  wire logic [WIDTH-1:0] push_data_in,
	// drain side
	output logic                  pop_valid_out,
	input  wire logic             pop_ready_in,
	output logic [WIDTH-1:0]      pop_data_out
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             full;
	logic             empty;

	assign full           = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty          = (wr_ptr == rd_ptr);
	assign push_ready_out = !full && !flush_in;
	assign pop_valid_out  = !empty && !flush_in;
	assign pop_data_out   = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge sys_clk_in) begin
		if (push_valid_in && push_ready_out) begin
			mem[wr_ptr[AW-1:0]] <= push_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else if (flush_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push_valid_in && push_ready_out) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop_valid_out && pop_ready_in) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// file: core/rxto_channel.sv
// one receive channel: rail/clock delivery to the terminal and analog local loop-back
// Notes on behaviour
// - dual rail: positive and negative rails go out with the recovered clock
// - without inversion, rail data changes on the recovered clock rising edge
// - recovered clock follows incoming line rate: E3, DS3 or STS-1 nominal
// - positive line pulse drives positive rail high for one bit period
// - negative line pulse drives negative rail high for one bit period
// - hardware mode: invert pin high launches data on falling clock edge
// - host mode: clock-invert bit D1 inverts the recovered clock against data
// - host mode: single-rail bit D4 gives binary data on positive rail
// - single rail holds the negative rail low constantly
// - hardware mode: single/dual pin low gives dual rail, high single rail
// - hardware mode: shutdown pin high powers receive down, low turns on
// - host mode: shutdown bit D2 powers channel receive down when set
// - analog local loop ignores line inputs, feeds transmit data into receive
// - host mode: local loop bit 1 with remote loop bit 0 selects it
// - hardware mode: local pin high with remote pin low selects it
`timescale 1ns/1ps
`default_nettype none

module rxto_channel (
	// clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       resetn_in,
	// mode and global pins
	input  wire logic       hardware_mode_in,
	input  wire logic       global_clock_invert_pin_in,
	input  wire logic       global_single_rail_pin_in,
	input  wire logic       receive_shutdown_pin_in,
	input  wire logic       local_loop_select_in,
	input  wire logic       remote_loop_select_in,
	// line receive side
	input  wire logic       line_receive_in_tip_in,
	input  wire logic       line_receive_in_ring_in,
	input  wire logic       line_bit_clock_in,
	// transmit side
	input  wire logic       tx_positive_data_in,
	input  wire logic       tx_negative_data_in,
	input  wire logic       transmit_clock_in,
	output logic            line_transmit_out_tip_out,
	output logic            line_transmit_out_ring_out,
	// command registers
	input  wire logic       reg_write_in,
	input  wire logic [2:0] reg_select_in,
	input  wire logic [4:0] reg_wdata_in,
	output logic [4:0]      reg_rdata_out,
	// terminal side
	output logic            rx_positive_rail_out,
	output logic            rx_negative_rail_out,
	output logic            recovered_clock_out,
	output logic            rx_overrun_out
);

	logic [rxto_pkg::RXTO_PIN_COUNT-1:0] pin_raw;
	logic [rxto_pkg::RXTO_PIN_COUNT-1:0] pin_meta;
	logic [rxto_pkg::RXTO_PIN_COUNT-1:0] pin_sync;
	logic [4:0]                          receive_output_control;
	logic [4:0]                          loopback_and_rate_control;
	logic                                line_clk_q;
	logic                                tx_clk_q;
	logic                                hw_mode;
	logic                                eff_invert;
	logic                                eff_single;
	logic                                eff_off;
	logic                                local_loop;
	logic                                src_edge;
	logic [1:0]                          src_bits;
	logic                                pend_valid;
	logic [1:0]                          pend_bits;
	logic                                push_ready;
	logic                                pop_valid;
	logic                                pop_ready;
	logic [1:0]                          pop_bits;
	rxto_pkg::rxto_state_t               state;
	rxto_pkg::rxto_state_t               next_state;

	assign pin_raw = {transmit_clock_in, tx_negative_data_in, tx_positive_data_in,
		line_bit_clock_in, line_receive_in_ring_in, line_receive_in_tip_in,
		remote_loop_select_in, local_loop_select_in, receive_shutdown_pin_in,
		global_single_rail_pin_in, global_clock_invert_pin_in, hardware_mode_in};

	// every pin is asynchronous to sys_clk_in
	genvar gi;
	generate
		for (gi = 0; gi < rxto_pkg::RXTO_PIN_COUNT; gi++) begin : g_sync
			always_ff @(posedge sys_clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					pin_meta[gi] <= 1'b0;
					pin_sync[gi] <= 1'b0;
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	// command registers, reserved bits read zero
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			receive_output_control    <= rxto_pkg::RXTO_OC_RESET;
			loopback_and_rate_control <= rxto_pkg::RXTO_LC_RESET;
		end else if (reg_write_in) begin
			if (reg_select_in == rxto_pkg::RXTO_REG_OUT_CTRL) begin
				receive_output_control <= reg_wdata_in & rxto_pkg::RXTO_OC_WRITE_MASK;
			end
			if (reg_select_in == rxto_pkg::RXTO_REG_LOOP_CTRL) begin
				loopback_and_rate_control <= reg_wdata_in & rxto_pkg::RXTO_LC_WRITE_MASK;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 5'h00;
		end else begin
			case (reg_select_in)
				rxto_pkg::RXTO_REG_OUT_CTRL: reg_rdata_out <= receive_output_control;
				rxto_pkg::RXTO_REG_LOOP_CTRL: reg_rdata_out <= loopback_and_rate_control;
				default: reg_rdata_out <= 5'h00;
			endcase
		end
	end

	// effective configuration: pins in hardware mode, registers in host mode
	assign hw_mode    = pin_sync[rxto_pkg::RXTO_PIN_HW_MODE];
	assign eff_invert = hw_mode ? pin_sync[rxto_pkg::RXTO_PIN_CLK_INV]
		: receive_output_control[rxto_pkg::RXTO_OC_CLK_INV_BIT];
	assign eff_single = hw_mode ? pin_sync[rxto_pkg::RXTO_PIN_SINGLE]
		: receive_output_control[rxto_pkg::RXTO_OC_SINGLE_RAIL_BIT];
	assign eff_off    = hw_mode ? pin_sync[rxto_pkg::RXTO_PIN_RX_OFF]
		: receive_output_control[rxto_pkg::RXTO_OC_RX_OFF_BIT];
	assign local_loop = hw_mode
		? (pin_sync[rxto_pkg::RXTO_PIN_LOCAL] && !pin_sync[rxto_pkg::RXTO_PIN_REMOTE])
		: (loopback_and_rate_control[rxto_pkg::RXTO_LC_LOCAL_LOOP_BIT]
			&& !loopback_and_rate_control[rxto_pkg::RXTO_LC_REMOTE_LOOP_BIT]);

	// edge detectors read only the second synchroniser stage
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			line_clk_q <= 1'b0;
			tx_clk_q   <= 1'b0;
		end else begin
			line_clk_q <= pin_sync[rxto_pkg::RXTO_PIN_LINE_CLK];
			tx_clk_q   <= pin_sync[rxto_pkg::RXTO_PIN_TX_CLK];
		end
	end

	// transmit data always reaches the line; encoder lives elsewhere
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			line_transmit_out_tip_out  <= 1'b0;
			line_transmit_out_ring_out <= 1'b0;
		end else if (pin_sync[rxto_pkg::RXTO_PIN_TX_CLK] && !tx_clk_q) begin
			line_transmit_out_tip_out  <= pin_sync[rxto_pkg::RXTO_PIN_TX_POS];
			line_transmit_out_ring_out <= pin_sync[rxto_pkg::RXTO_PIN_TX_NEG];
		end
	end

	// bit timing comes from the source clock, so the output rate tracks the line
	always_comb begin
		if (local_loop) begin
			src_edge = pin_sync[rxto_pkg::RXTO_PIN_TX_CLK] && !tx_clk_q;
			src_bits = {pin_sync[rxto_pkg::RXTO_PIN_TX_POS], pin_sync[rxto_pkg::RXTO_PIN_TX_NEG]};
		end else begin
			src_edge = pin_sync[rxto_pkg::RXTO_PIN_LINE_CLK] && !line_clk_q;
			src_bits = {pin_sync[rxto_pkg::RXTO_PIN_TIP], pin_sync[rxto_pkg::RXTO_PIN_RING]};
		end
	end

	// one-bit holding stage; a full fifo stalls it, a second bit then is an overrun
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pend_valid     <= 1'b0;
			pend_bits      <= 2'b00;
			rx_overrun_out <= 1'b0;
		end else if (eff_off) begin
			pend_valid     <= 1'b0;
			rx_overrun_out <= 1'b0;
		end else begin
			rx_overrun_out <= src_edge && pend_valid && !push_ready;
			if (src_edge && (!pend_valid || push_ready)) begin
				pend_valid <= 1'b1;
				pend_bits  <= src_bits;
			end else if (push_ready) begin
				pend_valid <= 1'b0;
			end
		end
	end

	rxto_fifo #(
		.WIDTH(rxto_pkg::RXTO_FIFO_WIDTH),
		.DEPTH(rxto_pkg::RXTO_FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in    (sys_clk_in),
		.resetn_in     (resetn_in),
		.flush_in      (eff_off),
		.push_valid_in (pend_valid),
		.push_ready_out(push_ready),
		.push_data_in  (pend_bits),
		.pop_valid_out (pop_valid),
		.pop_ready_in  (pop_ready),
		.pop_data_out  (pop_bits)
	);

	// two system cycles per bit: launch phase then hold phase
	assign pop_ready = (state != rxto_pkg::RXTO_ST_LAUNCH) && !eff_off;

	always_comb begin
		next_state = state;
		case (state)
			rxto_pkg::RXTO_ST_IDLE:   next_state = pop_valid && pop_ready ? rxto_pkg::RXTO_ST_LAUNCH
				: rxto_pkg::RXTO_ST_IDLE;
			rxto_pkg::RXTO_ST_LAUNCH: next_state = rxto_pkg::RXTO_ST_HOLD;
			rxto_pkg::RXTO_ST_HOLD:   next_state = pop_valid && pop_ready ? rxto_pkg::RXTO_ST_LAUNCH
				: rxto_pkg::RXTO_ST_IDLE;
			default:                  next_state = rxto_pkg::RXTO_ST_IDLE;
		endcase
		if (eff_off) begin
			next_state = rxto_pkg::RXTO_ST_IDLE;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= rxto_pkg::RXTO_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// launch level is high unless inverted, so data moves on the chosen edge
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			recovered_clock_out <= 1'b0;
		end else if (eff_off) begin
			recovered_clock_out <= 1'b0;
		end else if (next_state == rxto_pkg::RXTO_ST_LAUNCH) begin
			recovered_clock_out <= !eff_invert;
		end else begin
			recovered_clock_out <= eff_invert;
		end
	end

	// mute enable is only stored here; loss detection sits outside this block
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_positive_rail_out <= 1'b0;
			rx_negative_rail_out <= 1'b0;
		end else if (eff_off) begin
			rx_positive_rail_out <= 1'b0;
			rx_negative_rail_out <= 1'b0;
		end else begin
			if (pop_valid && pop_ready) begin
				rx_positive_rail_out <= eff_single ? (pop_bits[1] | pop_bits[0]) : pop_bits[1];
				rx_negative_rail_out <= !eff_single && pop_bits[0];
			end else if (eff_single) begin
				rx_negative_rail_out <= 1'b0;
			end
		end
	end

	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	sequence s_launch;
		pop_valid && pop_ready && !eff_off;
	endsequence

	sequence s_bit_cycle;
		recovered_clock_out != eff_invert ##1 recovered_clock_out == eff_invert;
	endsequence

	a_dual_rail_bit: assert property (s_launch and !eff_single and !$changed(eff_invert) |=> s_bit_cycle)
		else $error("recovered clock did not run one launch and one hold phase");
	// shutdown zeroes rails and clock at once, so it is kept out of the edge checks
	a_rise_moves_data: assert property ($changed(rx_positive_rail_out) && !$past(eff_invert) && !$past(eff_off)
		|-> $rose(recovered_clock_out))
		else $error("rail data moved without a rising recovered clock");
	a_fall_moves_data: assert property ($changed(rx_positive_rail_out) && $past(eff_invert) && !$past(eff_off)
		|-> $fell(recovered_clock_out))
		else $error("inverted clock did not fall with the rail data");
	a_pos_pulse_out: assert property (s_launch and pop_bits[1] |=> rx_positive_rail_out)
		else $error("positive pulse not shown on positive rail");
	a_neg_pulse_out: assert property (s_launch and pop_bits[0] and !eff_single |=> rx_negative_rail_out)
		else $error("negative pulse not shown on negative rail");
	a_single_rail_data: assert property (s_launch and eff_single
		|=> rx_positive_rail_out == $past(pop_bits[1] | pop_bits[0]))
		else $error("single rail data wrong on positive rail");
	a_single_neg_low: assert property (eff_single [*2] |-> !rx_negative_rail_out)
		else $error("negative rail not low in single rail");
	a_hw_pin_single: assert property (hw_mode && pin_sync[rxto_pkg::RXTO_PIN_SINGLE] |-> eff_single)
		else $error("hardware single rail pin ignored");
	a_shutdown_quiet: assert property (eff_off [*2] |-> !rx_positive_rail_out && !rx_negative_rail_out
		&& !recovered_clock_out && state == rxto_pkg::RXTO_ST_IDLE)
		else $error("receive section active while shut down");
	a_loop_ignores_line: assert property (local_loop && !eff_off && pin_sync[rxto_pkg::RXTO_PIN_TX_CLK]
		&& !tx_clk_q && (!pend_valid || push_ready)
		|=> pend_bits == $past({pin_sync[rxto_pkg::RXTO_PIN_TX_POS], pin_sync[rxto_pkg::RXTO_PIN_TX_NEG]}))
		else $error("local loop did not capture transmit data");
	a_host_loop_sel: assert property (!hw_mode && loopback_and_rate_control[1:0] == 2'h2 |-> local_loop)
		else $error("host loop bits did not select local loop");
	a_normal_path: assert property (!local_loop && !eff_off && pin_sync[rxto_pkg::RXTO_PIN_LINE_CLK]
		&& !line_clk_q && (!pend_valid || push_ready)
		|=> pend_valid && pend_bits == $past({pin_sync[rxto_pkg::RXTO_PIN_TIP], pin_sync[rxto_pkg::RXTO_PIN_RING]}))
		else $error("line data not captured in normal mode");

	sequence s_tx_edge;
		pin_sync[rxto_pkg::RXTO_PIN_TX_CLK] && !tx_clk_q;
	endsequence

	// clock level tracks the phase, so the terminal sampling edge stays fixed
	a_launch_clock_level: assert property (state == rxto_pkg::RXTO_ST_LAUNCH && !$changed(eff_invert)
		|-> recovered_clock_out != eff_invert)
		else $error("recovered clock not at launch level");
	a_hold_clock_level: assert property (state != rxto_pkg::RXTO_ST_LAUNCH && !$past(eff_off)
		&& !$changed(eff_invert) |-> recovered_clock_out == eff_invert)
		else $error("recovered clock not at hold level");
	a_launch_to_hold: assert property (state == rxto_pkg::RXTO_ST_LAUNCH && !eff_off
		|=> state == rxto_pkg::RXTO_ST_HOLD)
		else $error("launch phase not followed by hold phase");
	a_dual_pos_rail: assert property (s_launch and !eff_single
		|=> rx_positive_rail_out == $past(pop_bits[1]))
		else $error("positive rail wrong in dual rail");
	a_dual_neg_rail: assert property (s_launch and !eff_single
		|=> rx_negative_rail_out == $past(pop_bits[0]))
		else $error("negative rail wrong in dual rail");
	a_off_flushes: assert property (eff_off |=> !pend_valid && !pop_valid)
		else $error("shutdown left bits queued");
	a_tx_reaches_line: assert property (s_tx_edge |=> line_transmit_out_tip_out == $past(pin_sync[rxto_pkg::RXTO_PIN_TX_POS])
		&& line_transmit_out_ring_out == $past(pin_sync[rxto_pkg::RXTO_PIN_TX_NEG]))
		else $error("transmit data did not reach the line outputs");
	a_hw_loop_sel: assert property (hw_mode && pin_sync[rxto_pkg::RXTO_PIN_LOCAL]
		&& !pin_sync[rxto_pkg::RXTO_PIN_REMOTE] |-> local_loop)
		else $error("hardware loop pins did not select local loop");
	a_both_loops_line: assert property (!hw_mode && loopback_and_rate_control[1:0] == 2'h3 |-> !local_loop)
		else $error("both loop bits wrongly selected local loop");
	a_host_invert_bit: assert property (!hw_mode
		|-> eff_invert == receive_output_control[rxto_pkg::RXTO_OC_CLK_INV_BIT])
		else $error("host clock invert bit ignored");
	a_host_off_bit: assert property (!hw_mode
		|-> eff_off == receive_output_control[rxto_pkg::RXTO_OC_RX_OFF_BIT])
		else $error("host shutdown bit ignored");
	a_hw_pin_off: assert property (hw_mode
		|-> eff_off == pin_sync[rxto_pkg::RXTO_PIN_RX_OFF])
		else $error("hardware shutdown pin ignored");

endmodule

`default_nettype wire

// file: tb/rxto_framer_model.sv
// terminal-side receiver model: samples the rails on the recovered clock hold edge
`timescale 1ns/1ps
`default_nettype none

module rxto_framer_model (
	// clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       resetn_in,
	// configuration the terminal is set up for
	input  wire logic       inv_in,
	input  wire logic       watch_in,
	// receive terminal link
	input  wire logic       rx_positive_rail_in,
	input  wire logic       rx_negative_rail_in,
	input  wire logic       recovered_clock_in,
	// observations
	output logic            sample_valid_out,
	output logic [1:0]      sample_out,
	output logic            edge_err_out
);
	logic       last_clk;
	logic [1:0] last_rails;
	logic       launch_edge;
	logic       hold_edge;

	// launch level is the inverse of the invert selection, hold level equals it
	assign launch_edge = (last_clk == inv_in) && (recovered_clock_in == !inv_in);
	assign hold_edge   = (last_clk == !inv_in) && (recovered_clock_in == inv_in);

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			last_clk <= 1'b0;
			last_rails <= 2'b00;
			sample_valid_out <= 1'b0;
			sample_out <= 2'b00;
			edge_err_out <= 1'b0;
		end else begin
			last_clk <= recovered_clock_in;
			last_rails <= {rx_positive_rail_in, rx_negative_rail_in};
			// data is taken mid-bit, away from the edge where it changes
			sample_valid_out <= watch_in && hold_edge;
			sample_out <= {rx_positive_rail_in, rx_negative_rail_in};
			edge_err_out <= watch_in && !launch_edge && ({rx_positive_rail_in, rx_negative_rail_in} != last_rails);
		end
	end
endmodule
`default_nettype wire

// file: tb/test_rx_terminal_output_and_loopback.sv
// self-checking bench for one receive channel with a terminal model on its outputs
`timescale 1ns/1ps
`default_nettype none

module test_rx_terminal_output_and_loopback;
	logic       sys_clk_in = 1'b0;
	logic       resetn_in = 1'b0;
	logic       hw_mode = 1'b0, inv_pin = 1'b0, sr_pin = 1'b0, off_pin = 1'b0, loc_pin = 1'b0, rem_pin = 1'b0;
	logic       tip = 1'b0, ring = 1'b0, line_clk = 1'b0, txp = 1'b0, txn = 1'b0, tx_clk = 1'b0;
	logic       reg_write = 1'b0;
	logic [2:0] reg_sel = 3'h0;
	logic [4:0] reg_wdata = 5'h00;
	logic       ltx_tip, ltx_ring, rpos, rneg, rclk, overrun;
	logic [4:0] rdata;
	logic       watch = 1'b0, frm_inv = 1'b0, smp_valid, edge_err;
	logic [1:0] smp, e, last_tx;
	logic       cfg_local = 1'b0, cfg_sr = 1'b0;
	logic [1:0] exp_q[$];
	int         error_cnt = 0;
	int         checks_done = 0;
	int         cycles = 0;

	always #20 sys_clk_in = ~sys_clk_in;

	rxto_channel rxto_channel_i (
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .hardware_mode_in(hw_mode),
		.global_clock_invert_pin_in(inv_pin), .global_single_rail_pin_in(sr_pin),
		.receive_shutdown_pin_in(off_pin), .local_loop_select_in(loc_pin), .remote_loop_select_in(rem_pin),
		.line_receive_in_tip_in(tip), .line_receive_in_ring_in(ring), .line_bit_clock_in(line_clk),
		.tx_positive_data_in(txp), .tx_negative_data_in(txn), .transmit_clock_in(tx_clk),
		.line_transmit_out_tip_out(ltx_tip), .line_transmit_out_ring_out(ltx_ring),
		.reg_write_in(reg_write), .reg_select_in(reg_sel), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata),
		.rx_positive_rail_out(rpos), .rx_negative_rail_out(rneg), .recovered_clock_out(rclk),
		.rx_overrun_out(overrun));

	rxto_framer_model rxto_framer_model_i (
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .inv_in(frm_inv), .watch_in(watch),
		.rx_positive_rail_in(rpos), .rx_negative_rail_in(rneg), .recovered_clock_in(rclk),
		.sample_valid_out(smp_valid), .sample_out(smp), .edge_err_out(edge_err));

	task automatic chk(string name, logic [4:0] seen, logic [4:0] expd);
		checks_done++;
		if (seen !== expd) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, expd, seen);
		end
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watcher: each terminal sample retires the oldest expected bit
	always @(posedge sys_clk_in) begin
		if (smp_valid) begin
			if (exp_q.size() == 0) begin
				chk("extra bit", {3'h0, smp}, 5'h1f);
			end else begin
				e = exp_q.pop_front();
				chk("rails", {3'h0, smp}, {3'h0, e});
			end
		end
		if (edge_err)
			chk("data edge", 5'h01, 5'h00);
		if (overrun === 1'b1)
			chk("overrun", 5'h01, 5'h00);
		cycles++;
		if (cycles == 12000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic wr(logic [2:0] s, logic [4:0] d);
		@(negedge sys_clk_in);
		reg_write <= 1'b1;
		reg_sel <= s;
		reg_wdata <= d;
		@(negedge sys_clk_in);
		reg_write <= 1'b0;
	endtask

	task automatic rd(logic [2:0] s, logic [4:0] expd);
		@(negedge sys_clk_in);
		reg_sel <= s;
		repeat (2) @(negedge sys_clk_in);
		chk("register", rdata, expd);
	endtask

	// a line pulse is positive, negative or absent, never both
	function automatic logic [1:0] pick();
		int r = $urandom % 3;
		return (r == 0) ? 2'b00 : ((r == 1) ? 2'b10 : 2'b01);
	endfunction

	// both sources run together so the unused one proves it is ignored
	task automatic send(int cnt, bit expect_out);
		logic [1:0] lb, tb2, s;
		for (int k = 0; k < cnt; k++) begin
			lb = pick();
			tb2 = pick();
			@(negedge sys_clk_in);
			{tip, ring} <= lb;
			{txp, txn} <= tb2;
			line_clk <= 1'b1;
			tx_clk <= 1'b1;
			last_tx = tb2;
			s = cfg_local ? tb2 : lb;
			if (expect_out)
				exp_q.push_back(cfg_sr ? {s[1] | s[0], 1'b0} : s);
			@(negedge sys_clk_in);
			line_clk <= 1'b0;
			tx_clk <= 1'b0;
		end
		// released source lines drift while their clocks stand still
		@(negedge sys_clk_in);
		{tip, ring, txp, txn} <= ~{tip, ring, txp, txn};
	endtask

	// unused configuration source carries the opposite setting
	task automatic cfg(logic hw, logic inv, logic sr, logic loc, logic rem, logic off);
		logic [4:0] oc, lc;
		oc = {sr, 1'b0, off, inv, 1'b0};
		lc = {3'h0, loc, rem};
		watch = 1'b0;
		@(negedge sys_clk_in);
		hw_mode <= hw;
		{inv_pin, sr_pin, off_pin, loc_pin, rem_pin} <= {inv, sr, off, loc, rem} ^ {5{!hw}};
		wr(rxto_pkg::RXTO_REG_OUT_CTRL, hw ? oc ^ 5'h16 : oc);
		wr(rxto_pkg::RXTO_REG_LOOP_CTRL, hw ? lc ^ 5'h03 : lc);
		rd(rxto_pkg::RXTO_REG_OUT_CTRL, hw ? oc ^ 5'h16 : oc);
		rd(rxto_pkg::RXTO_REG_LOOP_CTRL, hw ? lc ^ 5'h03 : lc);
		repeat (10) @(negedge sys_clk_in);
		cfg_local = loc && !rem;
		cfg_sr = sr;
		frm_inv = inv;
		watch = 1'b1;
	endtask

	initial begin
		void'($urandom(56));
		repeat (12) @(negedge sys_clk_in);
		resetn_in <= 1'b1;
		rd(rxto_pkg::RXTO_REG_OUT_CTRL, rxto_pkg::RXTO_OC_RESET);
		rd(rxto_pkg::RXTO_REG_LOOP_CTRL, rxto_pkg::RXTO_LC_RESET);
		chk("clock after reset", {4'h0, rclk}, 5'h00);
		// reserved bits drop, unmapped selects read zero and store nothing
		wr(rxto_pkg::RXTO_REG_OUT_CTRL, 5'h1f);
		rd(rxto_pkg::RXTO_REG_OUT_CTRL, rxto_pkg::RXTO_OC_WRITE_MASK);
		wr(rxto_pkg::RXTO_REG_LOOP_CTRL, 5'h1f);
		rd(rxto_pkg::RXTO_REG_LOOP_CTRL, rxto_pkg::RXTO_LC_WRITE_MASK);
		wr(3'h7, 5'h00);
		rd(3'h7, 5'h00);
		rd(rxto_pkg::RXTO_REG_OUT_CTRL, rxto_pkg::RXTO_OC_WRITE_MASK);
		// every mode, invert, format and loop selection from pins and registers
		for (int i = 0; i < 32; i++) begin
			cfg(i[0], i[1], i[2], i[4], i[3], 1'b0);
			chk("idle clock", {4'h0, rclk}, {4'h0, i[1]});
			send(6, 1'b1);
			repeat (20) @(negedge sys_clk_in);
			chk("drained", 5'(exp_q.size()), 5'h00);
			chk("line out", {3'h0, ltx_tip, ltx_ring}, {3'h0, last_tx});
			if (i[2])
				chk("single neg", {4'h0, rneg}, 5'h00);
		end
		// receive shutdown by pin, then by register bit
		for (int h = 1; h >= 0; h--) begin
			cfg(h[0], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
			send(4, 1'b1);
			repeat (16) @(negedge sys_clk_in);
			cfg(h[0], 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
			send(4, 1'b0);
			repeat (16) @(negedge sys_clk_in);
			chk("off outputs", {2'h0, rpos, rneg, rclk}, 5'h00);
			cfg(h[0], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
			send(4, 1'b1);
			repeat (20) @(negedge sys_clk_in);
			chk("back on", 5'(exp_q.size()), 5'h00);
		end
		conclude();
	end
endmodule
`default_nettype wire
